// ---- design/svw_supervisor.sv ----
// Module: power-up reset, low-supply reset, watchdog and write-cycle timing
`timescale 1ns/1ps
`default_nettype none
module svw_supervisor #(
	parameter longint unsigned PURST_CYC = svw_pkg::PURST_CYC,
	parameter longint unsigned RST_CYC   = svw_pkg::RST_CYC,
	parameter longint unsigned WDT10_CYC = svw_pkg::WDT_SEL10_CYC,
	parameter longint unsigned WDT01_CYC = svw_pkg::WDT_SEL01_CYC,
	parameter longint unsigned WDT00_CYC = svw_pkg::WDT_SEL00_CYC,
	parameter longint unsigned NVW_CYC   = svw_pkg::NVW_CYC
) (
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire logic       low_supply,
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       wp,
	input  wire logic       write_seq_valid,
	input  wire logic       wdt_period_sel_msb,
	input  wire logic       wdt_period_sel_lsb,
	input  wire logic       wdt_sel_load,
	output logic            reset_out,
	output logic            bus_enable,
	output logic            bus_abort,
	output logic            nv_write_busy,
	output logic            wdt_expired,
	output logic            scl_filt,
	output logic            sda_filt,
	output logic            wp_filt
);
	localparam int unsigned CW = svw_pkg::CNT_W;

	svw_filt_if fif ();
	svw_glitch_filt #(.N_IN(3)) u_filt (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.pins     (fif.filt)
	);
	assign fif.scl_raw = scl;
	assign fif.sda_raw = sda;
	assign fif.wp_raw  = wp;

	logic                 low_m;
	logic                 low_s;
	svw_pkg::svw_state_e  state;
	svw_pkg::svw_state_e  next_state;
	logic [CW-1:0]        tmr;
	logic [CW-1:0]        wdt_cnt;
	logic [CW-1:0]        nvw_cnt;
	logic [1:0]           wdt_sel;
	logic                 scl_q;
	logic                 sda_q;

	// Low-supply level sync: two flops, 8 ns total, well inside the limit
	always_ff @(posedge core_clk) begin
		low_m <= low_supply;
		low_s <= low_m;
	end

	wire logic       in_reset;
	wire logic       tmr_done;
	wire logic       start_cond;
	wire logic       stop_cond;
	wire logic       bus_act;
	wire logic       wdt_on;
	wire logic [CW-1:0] wdt_limit;
	wire logic       wdt_hit;
	wire logic       nv_start;
	wire logic [1:0] sel_in;

	assign in_reset   = (state != svw_pkg::SVW_ST_RUN) || low_s;
	assign tmr_done   = tmr == '0;
	// Qualified bus events only when out of reset
	assign start_cond = !in_reset && scl_q && fif.scl_clean && sda_q && !fif.sda_clean;
	assign stop_cond  = !in_reset && scl_q && fif.scl_clean && !sda_q && fif.sda_clean;
	assign bus_act    = !in_reset && (scl_q != fif.scl_clean);
	assign sel_in     = {wdt_period_sel_msb, wdt_period_sel_lsb};
	assign wdt_on     = wdt_sel != svw_pkg::WDT_SEL_OFF;
	assign wdt_limit  = (wdt_sel == svw_pkg::WDT_SEL_SHORT) ? CW'(WDT10_CYC - 1) :
	                    (wdt_sel == svw_pkg::WDT_SEL_MID)   ? CW'(WDT01_CYC - 1) :
	                                                          CW'(WDT00_CYC - 1);
	assign wdt_hit    = wdt_on && !in_reset && (wdt_cnt == wdt_limit);
	assign nv_start   = stop_cond && write_seq_valid && (nvw_cnt == '0);

	always_comb begin
		next_state = state;
		unique case (state)
			svw_pkg::SVW_ST_POWERUP: if (tmr_done) next_state = svw_pkg::SVW_ST_RUN;
			svw_pkg::SVW_ST_RUN:     if (low_s || wdt_hit) next_state = svw_pkg::SVW_ST_RSTOUT;
			svw_pkg::SVW_ST_RSTOUT:  if (tmr_done && !low_s) next_state = svw_pkg::SVW_ST_RUN;
			default:                 next_state = svw_pkg::SVW_ST_POWERUP;
		endcase
	end

	// Reset sequencer state
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state <= svw_pkg::SVW_ST_POWERUP;
		end else begin
			state <= next_state;
		end
	end

	// Interval timer, reloaded on entry to reset and while supply is low
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			tmr <= CW'(PURST_CYC - 1);
		end else if (state == svw_pkg::SVW_ST_RUN && next_state == svw_pkg::SVW_ST_RSTOUT) begin
			tmr <= CW'(RST_CYC - 1);
		end else if (low_s) begin
			tmr <= CW'(RST_CYC - 1);
		end else if (!tmr_done) begin
			tmr <= tmr - CW'(1);
		end
	end

	// Watchdog period select, held between loads
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			wdt_sel <= svw_pkg::WDT_SEL_RESET;
		end else if (wdt_sel_load && !in_reset) begin
			wdt_sel <= sel_in;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b || in_reset || bus_act || !wdt_on) begin
			wdt_cnt <= '0;
		end else begin
			wdt_cnt <= wdt_cnt + CW'(1);
		end
	end

	// Self-timed write runs to completion once begun
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			nvw_cnt <= '0;
		end else if (nv_start) begin
			nvw_cnt <= CW'(NVW_CYC);
		end else if (nvw_cnt != '0) begin
			nvw_cnt <= nvw_cnt - CW'(1);
		end
	end

	// Output values, decided one cycle ahead
	wire logic next_reset_out;
	wire logic next_bus_enable;
	wire logic next_bus_abort;
	wire logic next_nv_write_busy;
	wire logic next_scl_filt;
	wire logic next_sda_filt;
	wire logic next_wp_filt;

	assign next_reset_out     = (next_state != svw_pkg::SVW_ST_RUN) || low_s;
	assign next_bus_enable    = !in_reset && (next_state == svw_pkg::SVW_ST_RUN);
	assign next_bus_abort     = bus_enable && (next_state != svw_pkg::SVW_ST_RUN || low_s);
	assign next_nv_write_busy = nv_start || (nvw_cnt > CW'(1));
	assign next_scl_filt      = in_reset ? 1'b1 : fif.scl_clean;
	assign next_sda_filt      = in_reset ? 1'b1 : fif.sda_clean;
	assign next_wp_filt       = in_reset ? 1'b0 : fif.wp_clean;

	// Previous filtered levels for start and stop detection
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= fif.scl_clean;
			sda_q <= fif.sda_clean;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			reset_out  <= 1'b1;
			bus_enable <= 1'b0;
			bus_abort  <= 1'b0;
		end else begin
			reset_out  <= next_reset_out;
			bus_enable <= next_bus_enable;
			bus_abort  <= next_bus_abort;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			nv_write_busy <= 1'b0;
			wdt_expired   <= 1'b0;
		end else begin
			nv_write_busy <= next_nv_write_busy;
			wdt_expired   <= wdt_hit;
		end
	end

	// Pins as the serial slave sees them, held idle in reset
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			scl_filt <= 1'b1;
			sda_filt <= 1'b1;
			wp_filt  <= 1'b0;
		end else begin
			scl_filt <= next_scl_filt;
			sda_filt <= next_sda_filt;
			wp_filt  <= next_wp_filt;
		end
	end
	// start_cond is available for future slave logic; bus_act sees only SCL edges, never a start
	wire logic unused_start;
	assign unused_start = start_cond;
endmodule : svw_supervisor
`default_nettype wire

// ---- design/svw_pkg.sv ----
// Package: timing constants and enums for the supervisor watchdog and reset timer
`default_nettype none
package svw_pkg;
	localparam int unsigned CLK_MHZ             = 250;
	// Times in their own units, as printed
	localparam int unsigned PURST_TYP_MS        = 250;
	localparam int unsigned RST_TYP_MS          = 250;
	localparam int unsigned WDT_SEL10_TYP_MS    = 250;
	localparam int unsigned WDT_SEL01_TYP_MS    = 650;
	localparam int unsigned WDT_SEL00_TYP_MS    = 1500;
	localparam int unsigned NVW_TYP_MS          = 5;
	localparam int unsigned RPD_MAX_NS          = 500;
	localparam int unsigned GLITCH_MIN_NS       = 50;
	// Cycle counts derived from the rate
	localparam longint unsigned CYC_PER_MS      = longint'(CLK_MHZ) * 1000;
	localparam longint unsigned PURST_CYC       = PURST_TYP_MS * CYC_PER_MS;
	localparam longint unsigned RST_CYC         = RST_TYP_MS * CYC_PER_MS;
	localparam longint unsigned WDT_SEL10_CYC   = WDT_SEL10_TYP_MS * CYC_PER_MS;
	localparam longint unsigned WDT_SEL01_CYC   = WDT_SEL01_TYP_MS * CYC_PER_MS;
	localparam longint unsigned WDT_SEL00_CYC   = WDT_SEL00_TYP_MS * CYC_PER_MS;
	localparam longint unsigned NVW_CYC         = NVW_TYP_MS * CYC_PER_MS;
	localparam int unsigned RPD_MAX_CYC         = (RPD_MAX_NS * CLK_MHZ) / 1000;
	localparam int unsigned GLITCH_CYC          = (GLITCH_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CNT_W               = 32;
	// Period select codes
	localparam logic [1:0] WDT_SEL_OFF          = 2'h3;
	localparam logic [1:0] WDT_SEL_SHORT        = 2'h2;
	localparam logic [1:0] WDT_SEL_MID          = 2'h1;
	localparam logic [1:0] WDT_SEL_LONG         = 2'h0;
	localparam logic [1:0] WDT_SEL_RESET        = WDT_SEL_OFF;
	typedef enum logic [1:0] {
		SVW_ST_POWERUP,
		SVW_ST_RUN,
		SVW_ST_RSTOUT
	} svw_state_e;
endpackage : svw_pkg
`default_nettype wire

// ---- design/svw_filt_if.sv ----
// Interface: raw and filtered serial pin levels between top and filter
`timescale 1ns/1ps
`default_nettype none
interface svw_filt_if;
	logic scl_raw;
	logic sda_raw;
	logic wp_raw;
	logic scl_clean;
	logic sda_clean;
	logic wp_clean;
	modport top (output scl_raw, sda_raw, wp_raw, input scl_clean, sda_clean, wp_clean);
	modport filt (input scl_raw, sda_raw, wp_raw, output scl_clean, sda_clean, wp_clean);
endinterface : svw_filt_if
`default_nettype wire

// ---- design/svw_glitch_filt.sv ----
// Module: synchroniser and narrow pulse suppression for serial inputs
`timescale 1ns/1ps
`default_nettype none
module svw_glitch_filt #(
	parameter int unsigned N_IN = 3
) (
	input  wire logic  core_clk,
	input  wire logic  rst_b,
	svw_filt_if.filt   pins
);
	localparam int unsigned FW = $clog2(svw_pkg::GLITCH_CYC + 1);
	localparam logic [FW-1:0] FMAX = FW'(svw_pkg::GLITCH_CYC);
	wire logic [N_IN-1:0] raw_in;
	wire logic [N_IN-1:0] clean;
	assign raw_in          = {pins.wp_raw, pins.sda_raw, pins.scl_raw};
	assign pins.scl_clean  = clean[0];
	assign pins.sda_clean  = clean[1];
	assign pins.wp_clean   = clean[2];
	genvar i;
	for (i = 0; i < N_IN; i++) begin : g_ch
		logic          meta;
		logic          sync;
		logic [FW-1:0] cnt;
		logic          level;
		wire logic     differs;
		assign clean[i] = level;
		assign differs  = sync != level;
		always_ff @(posedge core_clk) begin
			meta <= raw_in[i];
			sync <= meta;
		end
		// Level must persist the suppression time before it is accepted
		always_ff @(posedge core_clk) begin
			if (!rst_b) begin
				cnt      <= '0;
				level    <= 1'b1;
			end else if (!differs) begin
				cnt <= '0;
			end else if (cnt == FMAX) begin
				cnt      <= '0;
				level    <= sync;
			end else begin
				cnt <= cnt + FW'(1);
			end
		end
	end
endmodule : svw_glitch_filt
`default_nettype wire

// ---- tb/svw_monitor.sv ----
// Checker: timing relations at the supervisor ports
`timescale 1ns/1ps
`default_nettype none
module svw_monitor (
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic low_supply,
	input  wire logic scl,
	input  wire logic reset_out,
	input  wire logic bus_enable,
	input  wire logic bus_abort,
	input  wire logic nv_write_busy,
	input  wire logic wdt_expired,
	input  wire logic scl_filt,
	input  wire logic sda_filt,
	input  wire logic wp_filt
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	sequence busy_start;
		$rose(nv_write_busy);
	endsequence
	sequence in_reset;
		reset_out ##1 reset_out;
	endsequence
	powerup_hold_a: assert property ($rose(rst_b) |-> reset_out[*8])
		else $error("reset output dropped early");
	low_trip_a: assert property ($rose(low_supply) |-> ##[0:125] reset_out)
		else $error("low supply reset late");
	bus_block_a: assert property (in_reset |-> !bus_enable)
		else $error("bus enabled in reset");
	abort_pulse_a: assert property (bus_abort |-> $past(bus_enable) ##1 !bus_abort)
		else $error("bad abort pulse");
	wdt_reset_a: assert property (wdt_expired |-> ##[0:2] reset_out ##1 !wdt_expired)
		else $error("timeout gave no reset");
	pin_idle_a: assert property (in_reset |-> scl_filt && sda_filt && !wp_filt)
		else $error("pins not idle in reset");
	write_time_a: assert property (busy_start |-> nv_write_busy[*8] ##[16:30] !nv_write_busy)
		else $error("write time wrong");
	glitch_block_a: assert property ($changed(scl_filt) && !reset_out && !$past(reset_out)
		|-> scl_filt == $past(scl, 8))
		else $error("short pulse passed");
endmodule : svw_monitor
bind svw_supervisor svw_monitor mon_u (.core_clk, .rst_b, .low_supply, .scl, .reset_out,
	.bus_enable, .bus_abort, .nv_write_busy, .wdt_expired, .scl_filt, .sda_filt, .wp_filt);
`default_nettype wire

// ---- tb/svw_host_model.sv ----
// Host model: drives the two-wire pins
`timescale 1ns/1ps
`default_nettype none
module svw_host_model (
	input  wire logic core_clk,
	output logic      scl,
	output logic      sda,
	output logic      wp
);
	initial begin
		scl = 1'h1;
		sda = 1'h1;
		wp = 1'h0;
	end
	task automatic step(input int n);
		repeat (n) @(negedge core_clk);
	endtask : step
	// Stop condition, each phase above filter length
	task automatic stop_cond;
		step(1);
		scl = 1'h0;
		step(14);
		sda = 1'h0;
		step(14);
		scl = 1'h1;
		step(14);
		sda = 1'h1;
		step(14);
	endtask : stop_cond
	task automatic pulse_sda(input int w);
		step(1);
		sda = 1'h0;
		step(w);
		sda = 1'h1;
	endtask : pulse_sda
	// Bus activity that restarts the watchdog
	task automatic kick(input int n);
		repeat (n) begin
			step(20);
			scl = ~scl;
		end
	endtask : kick
	task automatic set_wp(input logic v);
		wp = v;
	endtask : set_wp
endmodule : svw_host_model
`default_nettype wire

// ---- tb/tb_svw_supervisor.sv ----
// Testbench: supervisor reset, watchdog and write timing
`timescale 1ns/1ps
`default_nettype none
module tb_svw_supervisor;
	logic core_clk, rst_b, low_supply, write_seq_valid;
	logic wdt_period_sel_msb, wdt_period_sel_lsb, wdt_sel_load;
	logic reset_out, bus_enable, bus_abort, nv_write_busy, wdt_expired;
	logic scl_filt, sda_filt, wp_filt;
	wire  scl, sda, wp;
	int   fail_count, comparisons, wdt_hits, abort_hits;
	svw_host_model host_u (.core_clk, .scl, .sda, .wp);
	svw_supervisor #(.PURST_CYC(100), .RST_CYC(80), .WDT10_CYC(50), .WDT01_CYC(70),
		.WDT00_CYC(90), .NVW_CYC(30)) dut_u (.core_clk, .rst_b, .low_supply, .scl, .sda,
		.wp, .write_seq_valid, .wdt_period_sel_msb, .wdt_period_sel_lsb, .wdt_sel_load,
		.reset_out, .bus_enable, .bus_abort, .nv_write_busy, .wdt_expired, .scl_filt,
		.sda_filt, .wp_filt);
	initial begin
		core_clk = 1'h0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (wdt_expired === 1'h1)
			wdt_hits++;
		if (bus_abort === 1'h1)
			abort_hits++;
	end
	task automatic stop_test;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	task automatic bad(input string m);
		fail_count++;
		$display("CHECK FAILED %0t %s", $time, m);
	endtask : bad
	task automatic chk(input logic got, input logic exp, input string m);
		comparisons++;
		if (got !== exp)
			bad(m);
	endtask : chk
	task automatic chk_n(input int got, input int lo, input int hi, input string m);
		comparisons++;
		if (got < lo || got > hi)
			bad(m);
	endtask : chk_n
	function automatic logic sig(input int s);
		case (s)
			0: return reset_out;
			1: return nv_write_busy;
			2: return wdt_expired;
			default: return bus_enable;
		endcase
	endfunction : sig
	task automatic wait_lvl(input int s, input logic v, input int lim, output int n);
		n = 0;
		while (sig(s) !== v && n < lim) begin
			@(negedge core_clk);
			n++;
		end
		if (sig(s) !== v) begin
			bad("wait timed out");
			stop_test();
		end
	endtask : wait_lvl
	task automatic load_sel(input logic [1:0] c);
		@(negedge core_clk);
		{wdt_period_sel_msb, wdt_period_sel_lsb} = c;
		wdt_sel_load = 1'h1;
		@(negedge core_clk);
		wdt_sel_load = 1'h0;
	endtask : load_sel
	task automatic t_powerup;
		int n;
		wait_lvl(3, 1'h1, 200, n);
		chk_n(n, 100, 103, "power-up hold");
	endtask : t_powerup
	task automatic t_write;
		int n;
		write_seq_valid = 1'h1;
		host_u.stop_cond();
		wait_lvl(1, 1'h1, 40, n);
		wait_lvl(1, 1'h0, 40, n);
		chk_n(n, 28, 31, "write time");
		write_seq_valid = 1'h0;
	endtask : t_write
	task automatic t_glitch;
		write_seq_valid = 1'h1;
		host_u.pulse_sda(8);
		repeat (30) begin
			@(negedge core_clk);
			chk(sda_filt, 1'h1, "glitch passed");
			chk(nv_write_busy, 1'h0, "glitch made stop");
		end
		write_seq_valid = 1'h0;
	endtask : t_glitch
	task automatic t_wdt;
		int n, h;
		logic [1:0] code [3] = '{2'h2, 2'h1, 2'h0};
		int per [3] = '{50, 70, 90};
		chk_n(wdt_hits, 0, 0, "default not off");
		for (int i = 0; i < 3; i++) begin
			load_sel(code[i]);
			wait_lvl(2, 1'h1, 150, n);
			chk_n(n, per[i] - 5, per[i] + 25, "watchdog period");
			wait_lvl(0, 1'h1, 5, n);
			wait_lvl(0, 1'h0, 150, n);
			chk_n(n, 77, 90, "reset timeout");
		end
		load_sel(2'h2);
		h = wdt_hits;
		host_u.kick(8);
		load_sel(2'h3);
		repeat (200) @(negedge core_clk);
		chk_n(wdt_hits - h, 0, 0, "watchdog fired");
	endtask : t_wdt
	task automatic t_lowsup;
		int n, a;
		a = abort_hits;
		low_supply = 1'h1;
		wait_lvl(0, 1'h1, 125, n);
		write_seq_valid = 1'h1;
		host_u.set_wp(1'h1);
		host_u.stop_cond();
		host_u.kick(1);
		repeat (20) begin
			@(negedge core_clk);
			chk(nv_write_busy, 1'h0, "write in reset");
			chk(scl_filt, 1'h1, "scl seen in reset");
			chk(wp_filt, 1'h0, "wp seen in reset");
		end
		chk_n(abort_hits - a, 1, 1, "abort pulse");
		write_seq_valid = 1'h0;
		host_u.kick(1);
		low_supply = 1'h0;
		wait_lvl(0, 1'h0, 150, n);
		chk_n(n, 80, 88, "low supply timeout");
		repeat (2) @(negedge core_clk);
		chk(wp_filt, 1'h1, "wp not passed");
		host_u.set_wp(1'h0);
		repeat (20) @(negedge core_clk);
		chk(wp_filt, 1'h0, "wp stuck");
	endtask : t_lowsup
	initial begin
		rst_b = 1'h0;
		low_supply = 1'h0;
		write_seq_valid = 1'h0;
		{wdt_period_sel_msb, wdt_period_sel_lsb} = 2'h3;
		wdt_sel_load = 1'h0;
		repeat (3) @(negedge core_clk);
		rst_b = 1'h1;
		t_powerup();
		t_write();
		t_glitch();
		t_wdt();
		t_lowsup();
		stop_test();
	end
endmodule : tb_svw_supervisor
`default_nettype wire
